// File: inc/hlt_pkg.sv
// Timing constants and state type for the host link bit timing block
package hlt_pkg;

	// ****************************************************************
	// Clock and counter sizing
	// ****************************************************************
	localparam real HLT_CLK_MHZ = 20.0; // Core clock rate
	localparam int HLT_CNT_W = 26; // Wide enough for a two second count

	// ****************************************************************
	// Single-wire host side timing
	// ****************************************************************
	localparam real HLT_BREAK_US = 190.0; // Shortest break low time
	localparam int HLT_BREAK_CYC = int'($ceil(HLT_BREAK_US * HLT_CLK_MHZ));
	// Sample point sits between longest one and shortest zero
	localparam real HLT_SAMPLE_US = 68.0;
	localparam int HLT_SAMPLE_CYC = int'($ceil(HLT_SAMPLE_US * HLT_CLK_MHZ));

	// ****************************************************************
	// Single-wire device side timing
	// ****************************************************************
	localparam real HLT_DEV_ONE_US = 40.0; // Nominal one low time
	localparam real HLT_DEV_ONE_MIN_US = 32.0;
	localparam real HLT_DEV_ONE_MAX_US = 50.0;
	localparam real HLT_DEV_ZERO_US = 110.0; // Nominal zero low time
	localparam real HLT_DEV_ZERO_MIN_US = 80.0;
	localparam real HLT_DEV_ZERO_MAX_US = 145.0;
	localparam real HLT_DEV_SLOT_US = 205.0; // Nominal slot length
	localparam real HLT_DEV_SLOT_MIN_US = 190.0;
	localparam real HLT_DEV_SLOT_MAX_US = 250.0;
	localparam real HLT_REPLY_US = 190.0; // Least reply delay
	localparam int HLT_DEV_ONE_CYC = int'($ceil(HLT_DEV_ONE_US * HLT_CLK_MHZ));
	localparam int HLT_DEV_ONE_MIN_CYC =
		int'($ceil(HLT_DEV_ONE_MIN_US * HLT_CLK_MHZ));
	localparam int HLT_DEV_ONE_MAX_CYC =
		int'($floor(HLT_DEV_ONE_MAX_US * HLT_CLK_MHZ));
	localparam int HLT_DEV_ZERO_CYC =
		int'($ceil(HLT_DEV_ZERO_US * HLT_CLK_MHZ));
	localparam int HLT_DEV_ZERO_MIN_CYC =
		int'($ceil(HLT_DEV_ZERO_MIN_US * HLT_CLK_MHZ));
	localparam int HLT_DEV_ZERO_MAX_CYC =
		int'($floor(HLT_DEV_ZERO_MAX_US * HLT_CLK_MHZ));
	localparam int HLT_DEV_SLOT_CYC =
		int'($ceil(HLT_DEV_SLOT_US * HLT_CLK_MHZ));
	localparam int HLT_DEV_SLOT_MIN_CYC =
		int'($ceil(HLT_DEV_SLOT_MIN_US * HLT_CLK_MHZ));
	localparam int HLT_DEV_SLOT_MAX_CYC =
		int'($floor(HLT_DEV_SLOT_MAX_US * HLT_CLK_MHZ));
	localparam int HLT_REPLY_CYC = int'($ceil(HLT_REPLY_US * HLT_CLK_MHZ));

	// ****************************************************************
	// Stuck-low bus reset timeouts
	// ****************************************************************
	localparam real HLT_LINK_RST_S = 2.0; // Single-wire hold-low reset
	localparam real HLT_SCL_RST_S = 2.0; // Two-wire clock stuck low
	localparam int HLT_LINK_RST_CYC =
		int'($floor(HLT_LINK_RST_S * 1.0e6 * HLT_CLK_MHZ));
	localparam int HLT_SCL_RST_CYC =
		int'($floor(HLT_SCL_RST_S * 1.0e6 * HLT_CLK_MHZ));

	// ****************************************************************
	// Link state machine
	// ****************************************************************
	typedef enum logic [2:0]
	{
		ST_IDLE, // Line released, waiting
		ST_RX, // Host holds line low in a slot
		ST_DRIVE, // Device pulls line low
		ST_GAP, // Device released, slot still running
		ST_HOLD // After break or reset, wait for release
	} hlt_state_e;

endpackage : hlt_pkg

// File: hdl/hlt_scl_watch.sv
// Two-wire clock stuck-low watchdog that resets the bus interface
`timescale 1ns/100ps

module hlt_scl_watch
	import hlt_pkg::*;
#(
	parameter int TIMEOUT_CYC = HLT_SCL_RST_CYC
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic scl_in,
	output logic bus_reset
);

	// ****************************************************************
	// Low-time counter
	// ****************************************************************
	localparam int CW = HLT_CNT_W;
	localparam logic [CW-1:0] C_TMO = CW'(TIMEOUT_CYC);

	logic [CW-1:0] cnt_r; // Cycles the clock line has been low
	logic [CW-1:0] cnt_nxt;
	logic bus_reset_r; // One-cycle reset pulse
	wire hit_w; // Timeout reached this cycle

	// Saturate so one long low gives a single pulse
	assign hit_w = !scl_in && (cnt_r == C_TMO - 1'b1);
	assign cnt_nxt = scl_in ? '0 : ((cnt_r == C_TMO) ? cnt_r : cnt_r + 1'b1);
	assign bus_reset = bus_reset_r;

	// Count low time, pulse on the timeout
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cnt_r <= '0;
			bus_reset_r <= 1'b0;
		end
		else if (ce)
		begin
			cnt_r <= cnt_nxt;
			bus_reset_r <= hit_w; // RL4
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_scl_timeout: assert property (@(posedge clk) disable iff (sys_rst) // RL4
		($past(ce) && bus_reset) |-> ($past(cnt_r) == C_TMO - 1'b1)
		&& !$past(scl_in))
	else $error("bus reset not at timeout");

endmodule : hlt_scl_watch

// File: hdl/hlt_link.sv
// Single-wire pulse-width link engine with two-wire stuck-clock watchdog
// Behaviour
// [RL1] Host standard clock: 100 kHz, 4.7/4.0 us
// [RL2] Host fast clock: 400 kHz, 1.3/0.6 us
// [RL3] Host bus free time before next start
// [RL4] Clock stuck low two seconds resets bus
// [RL5] Host break 190 us, recovery 40 us
// [RL6] Host one: low 0.5 to 50 us
// [RL7] Host zero: low 86 to 145 us
// [RL8] Host slot at least 190 us
// [RL9] Device one: low 32 to 50 us
// [RL10] Device zero: low 80 to 145 us
// [RL11] Device slot 190 to 250 us, 205 nominal
// [RL12] Reply waits at least 190 us idle
// [RL13] Host waits 210 us after reply
// [RL14] Line held low two seconds resets link
// [RL15] Decode host bit at fixed sample delay
// [RL16] Long low is break, aborts, rearms receive
`timescale 1ns/100ps

module hlt_link
	import hlt_pkg::*;
#(
	parameter int SLOT_CYC = HLT_DEV_SLOT_CYC,
	parameter int RST_CYC = HLT_LINK_RST_CYC,
	parameter int SCL_RST_CYC = HLT_SCL_RST_CYC
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic lw_in,
	output logic lw_out,
	output logic lw_oe,
	output logic rx_valid,
	output logic rx_bit,
	output logic rx_break,
	output logic link_reset,
	input wire logic tx_valid,
	input wire logic tx_bit,
	output logic tx_ready,
	output logic tx_busy,
	input wire logic scl_in,
	output logic i2c_bus_reset
);

	// ****************************************************************
	// Cycle counts at counter width
	// ****************************************************************
	localparam int CW = HLT_CNT_W;
	localparam logic [CW-1:0] C_BRK = CW'(HLT_BREAK_CYC);
	localparam logic [CW-1:0] C_SMP = CW'(HLT_SAMPLE_CYC);
	localparam logic [CW-1:0] C_ONE = CW'(HLT_DEV_ONE_CYC);
	localparam logic [CW-1:0] C_ZERO = CW'(HLT_DEV_ZERO_CYC);
	localparam logic [CW-1:0] C_SLOT = CW'(SLOT_CYC);
	localparam logic [CW-1:0] C_RPL = CW'(HLT_REPLY_CYC);
	localparam logic [CW-1:0] C_RST = CW'(RST_CYC);

	// ****************************************************************
	// State and counters
	// ****************************************************************
	hlt_state_e state_r; // Link state
	hlt_state_e state_nxt;
	logic [CW-1:0] low_cnt_r; // Length of the current host low
	logic [CW-1:0] low_cnt_nxt;
	logic [CW-1:0] slot_cnt_r; // Position inside a device slot
	logic [CW-1:0] slot_cnt_nxt;
	logic [CW-1:0] quiet_cnt_r; // Idle-high time, saturates at reply
	logic [CW-1:0] quiet_cnt_nxt;
	logic cur_bit_r; // Bit being sent
	logic rx_valid_r; // Received bit pulse
	logic rx_bit_r; // Received bit value
	logic rx_break_r; // Break pulse
	logic link_reset_r; // Hold-low reset pulse

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire drive_w = (state_r == ST_DRIVE); // Device pulls line
	wire host_low_w = !lw_in && !drive_w; // Low not of our making
	wire brk_hit_w = host_low_w && (low_cnt_r == C_BRK - 1'b1);
	wire rst_hit_w = host_low_w && (low_cnt_r == C_RST - 1'b1);
	wire slot_done_w = (slot_cnt_r == C_SLOT - 1'b1);
	wire [CW-1:0] low_len_w = cur_bit_r ? C_ONE : C_ZERO;
	wire drive_end_w = (slot_cnt_r == low_len_w - 1'b1);
	wire quiet_ok_w = (quiet_cnt_r == C_RPL);
	wire rise_w = (state_r == ST_RX) && lw_in; // End of a host low
	// First bit only after the idle delay, later ones at slot end
	wire idle_ok_w = (state_r == ST_IDLE) && lw_in && quiet_ok_w; // RL12
	wire gap_ok_w = (state_r == ST_GAP) && lw_in && slot_done_w; // RL11
	wire tx_fire_w = tx_valid && tx_ready;

	assign tx_ready = ce && (idle_ok_w || gap_ok_w);
	assign tx_busy = (state_r == ST_DRIVE) || (state_r == ST_GAP);
	assign lw_out = 1'b0; // Open drain, only ever pulls low
	assign lw_oe = drive_w;
	assign rx_valid = rx_valid_r;
	assign rx_bit = rx_bit_r;
	assign rx_break = rx_break_r;
	assign link_reset = link_reset_r;

	// Host low length, saturating so a long hold pulses once
	assign low_cnt_nxt = !host_low_w ? '0 :
		((low_cnt_r == C_RST) ? low_cnt_r : low_cnt_r + 1'b1);
	// Slot position restarts with each accepted bit
	assign slot_cnt_nxt = tx_fire_w ? '0 :
		(tx_busy ? slot_cnt_r + 1'b1 : '0);
	// Leaving a reply lets further bits go without a fresh wait
	assign quiet_cnt_nxt = (state_r == ST_GAP) ? C_RPL :
		(!lw_in ? '0 : (quiet_ok_w ? quiet_cnt_r : quiet_cnt_r + 1'b1));

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE:
			begin
				if (tx_fire_w)
					state_nxt = ST_DRIVE; // Start reply bit
				else if (!lw_in)
					state_nxt = ST_RX; // Host falling edge
			end
			ST_RX:
			begin
				if (lw_in)
					state_nxt = ST_IDLE; // Bit ends on release
			end
			ST_DRIVE:
			begin
				if (drive_end_w)
					state_nxt = ST_GAP; // RL9 RL10
			end
			ST_GAP:
			begin
				if (tx_fire_w)
					state_nxt = ST_DRIVE; // Back-to-back reply bit
				else if (slot_done_w)
					state_nxt = ST_IDLE;
			end
			ST_HOLD:
			begin
				if (lw_in)
					state_nxt = ST_IDLE; // Rearmed after release
			end
		endcase
		// A long host low overrides any partial transfer
		if (brk_hit_w || rst_hit_w)
			state_nxt = ST_HOLD; // RL16
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Core state and counters
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_r <= ST_IDLE;
			low_cnt_r <= '0;
			slot_cnt_r <= '0;
			quiet_cnt_r <= '0;
			cur_bit_r <= 1'b0;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			low_cnt_r <= low_cnt_nxt;
			slot_cnt_r <= slot_cnt_nxt;
			quiet_cnt_r <= quiet_cnt_nxt;
			if (tx_fire_w)
				cur_bit_r <= tx_bit;
		end
	end

	// Receive pulses; a rise after a break gives no bit
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rx_valid_r <= 1'b0;
			rx_bit_r <= 1'b0;
			rx_break_r <= 1'b0;
			link_reset_r <= 1'b0;
		end
		else if (ce)
		begin
			rx_valid_r <= rise_w;
			if (rise_w)
				rx_bit_r <= (low_cnt_r < C_SMP); // RL15
			rx_break_r <= brk_hit_w; // RL16
			link_reset_r <= rst_hit_w; // RL14
		end
	end

	// ****************************************************************
	// Two-wire watchdog
	// ****************************************************************
	hlt_scl_watch #(
		.TIMEOUT_CYC(SCL_RST_CYC)
	) u_scl_watch (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.scl_in(scl_in),
		.bus_reset(i2c_bus_reset)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic [CW-1:0] oe_len_r; // Cycles the line has been driven
	logic [CW-1:0] slot_len_r; // Cycles since the last accepted bit

	// Helper counters seen only by the checks
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			oe_len_r <= '0;
			slot_len_r <= '0;
		end
		else if (ce)
		begin
			oe_len_r <= lw_oe ? oe_len_r + 1'b1 : '0;
			slot_len_r <= tx_fire_w ? '0 : slot_len_r + 1'b1;
		end
	end

	sequence s_short_low;
		(state_r == ST_RX) && lw_in && ce;
	endsequence

	a_one_low_len: assert property (@(posedge clk) disable iff (sys_rst) // RL9
		($fell(lw_oe) && cur_bit_r) |->
		(oe_len_r >= CW'(HLT_DEV_ONE_MIN_CYC))
		&& (oe_len_r <= CW'(HLT_DEV_ONE_MAX_CYC)))
	else $error("one low time out of range");

	a_zero_low_len: assert property (@(posedge clk) disable iff (sys_rst) // RL10
		($fell(lw_oe) && !cur_bit_r) |->
		(oe_len_r >= CW'(HLT_DEV_ZERO_MIN_CYC))
		&& (oe_len_r <= CW'(HLT_DEV_ZERO_MAX_CYC)))
	else $error("zero low time out of range");

	a_slot_len: assert property (@(posedge clk) disable iff (sys_rst) // RL11
		(tx_fire_w && (state_r == ST_GAP)) |->
		(slot_len_r >= CW'(HLT_DEV_SLOT_MIN_CYC - 1))
		&& (slot_len_r <= CW'(HLT_DEV_SLOT_MAX_CYC - 1)))
	else $error("device slot length out of range");

	a_reply_wait: assert property (@(posedge clk) disable iff (sys_rst) // RL12
		(tx_fire_w && (state_r == ST_IDLE)) |->
		(quiet_cnt_r >= C_RPL) && $past(lw_in))
	else $error("reply started too early");

	a_bit_decode: assert property (@(posedge clk) disable iff (sys_rst) // RL15
		($past(ce) && rx_valid) |-> (rx_bit == ($past(low_cnt_r) < C_SMP)))
	else $error("host bit decoded wrongly");

	a_bit_after_rise: assert property (@(posedge clk) disable iff (sys_rst) // RL15
		s_short_low |=> rx_valid ##1 (!rx_valid || !$past(ce)))
	else $error("host bit not reported once");

	a_break_flag: assert property (@(posedge clk) disable iff (sys_rst) // RL16
		($past(ce) && rx_break) |->
		($past(low_cnt_r) == C_BRK - 1'b1) && !$past(lw_in))
	else $error("break flagged at wrong time");

	a_break_abort: assert property (@(posedge clk) disable iff (sys_rst) // RL16
		rx_break |-> (state_r == ST_HOLD) && !lw_oe && !rx_valid)
	else $error("break did not abort transfer");

	a_link_reset: assert property (@(posedge clk) disable iff (sys_rst) // RL14
		($past(ce) && link_reset) |->
		($past(low_cnt_r) == C_RST - 1'b1) && (state_r == ST_HOLD))
	else $error("link reset at wrong time");

endmodule : hlt_link

// File: verif/hlt_host.sv
// Host processor model for the single-wire line and two-wire clock
`timescale 1ns/100ps

module hlt_host
(
	input wire logic clk,
	output logic lw_pull,
	output logic scl_pull
);
	// ****************************************************************
	// Open-drain drivers: high means line held low
	// ****************************************************************
	initial
	begin
		lw_pull = 1'b0;
		scl_pull = 1'b0;
	end

	// Low for lo cycles, then released for hi; caller sits on an edge
	task automatic pulse(input int lo, input int hi);
		lw_pull <= 1'b1;
		repeat (lo) @(posedge clk);
		lw_pull <= 1'b0;
		repeat (hi) @(posedge clk);
	endtask : pulse

	// Break of 200 us, then 40 us recovery
	task automatic brk();
		pulse(4000, 800);
	endtask : brk

	// One host bit in a 190 us slot; lo picks the value
	task automatic send(input int lo);
		pulse(lo, 3800 - lo);
	endtask : send

	// Quiet spell after a device reply, 210 us
	task automatic turn();
		repeat (4200) @(posedge clk);
	endtask : turn

	// Clock burst, then bus free time of one low period
	task automatic scl_run(input int n, input int lo, input int hi);
		repeat (n)
		begin
			scl_pull <= 1'b1;
			repeat (lo) @(posedge clk);
			scl_pull <= 1'b0;
			repeat (hi) @(posedge clk);
		end
		repeat (lo) @(posedge clk);
	endtask : scl_run

	// Clock held low for n cycles, then a short settle
	task automatic scl_hold(input int n);
		scl_pull <= 1'b1;
		repeat (n) @(posedge clk);
		scl_pull <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : scl_hold
endmodule : hlt_host

// File: verif/host_link_bit_timing_bench.sv
// Self-checking bench for the single-wire link engine
`timescale 1ns/100ps

module host_link_bit_timing_bench;
	import hlt_pkg::*;
	localparam int RST_N = 5000; // Shortened two second timeouts
	logic clk, sys_rst, ce, tx_valid, tx_bit;
	logic lw_out, lw_oe, rx_valid, rx_bit, rx_break, link_reset;
	logic tx_ready, tx_busy, i2c_bus_reset, lw_pull, scl_pull;
	// Pull-ups: a released line reads high
	wire logic lw_line = !(lw_pull || (lw_oe && !lw_out));
	wire logic scl_line = !scl_pull;
	int mismatches = 0, n_tests = 0, n_brk = 0, n_lrst = 0, n_scl = 0;
	int cyc = 0, hi_c = 0, quiet = 0;
	logic rxq[$]; // Received bits
	int hq[$]; // Device low lengths
	int rq[$]; // Cycle of each device pull

	hlt_link #(.RST_CYC(RST_N), .SCL_RST_CYC(RST_N)) u_dut (.clk(clk),
		.sys_rst(sys_rst), .ce(ce), .lw_in(lw_line), .lw_out(lw_out),
		.lw_oe(lw_oe), .rx_valid(rx_valid), .rx_bit(rx_bit),
		.rx_break(rx_break), .link_reset(link_reset), .tx_valid(tx_valid),
		.tx_bit(tx_bit), .tx_ready(tx_ready), .tx_busy(tx_busy),
		.scl_in(scl_line), .i2c_bus_reset(i2c_bus_reset));
	hlt_host u_host (.clk(clk), .lw_pull(lw_pull), .scl_pull(scl_pull));

	// ****************************************************************
	// Clock, monitor and compare helpers
	// ****************************************************************
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Records pulses and device drive timing as they happen
	always @(posedge clk)
	begin
		cyc++;
		quiet = lw_line ? quiet + 1 : 0;
		if (rx_valid === 1'b1) rxq.push_back(rx_bit);
		if (rx_break === 1'b1) n_brk++;
		if (link_reset === 1'b1) n_lrst++;
		if (i2c_bus_reset === 1'b1) n_scl++;
		if (lw_oe === 1'b1)
		begin
			if (hi_c == 0) rq.push_back(cyc);
			hi_c++;
		end
		else if (hi_c != 0)
		begin
			hq.push_back(hi_c);
			hi_c = 0;
		end
	end

	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %0d seen %0d", w, e, g);
		end
	endtask : chk

	// Range compare; prints both bounds so a miss is easy to read
	task automatic rng(input string w, input int lo, input int hi,
		input int g);
		n_tests++;
		if ((g < lo) || (g > hi))
		begin
			mismatches++;
			$display("Error %s expected %0d to %0d seen %0d", w, lo, hi, g);
		end
	endtask : rng

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Shortest and longest lows of each value, back to back
	task automatic t_rx();
		int lows[4] = '{10, 1000, 1720, 2900};
		rxq.delete();
		foreach (lows[i]) u_host.send(lows[i]);
		chk("bit count", 4, rxq.size());
		for (int i = 0; i < 4; i++) chk("rx bit", i < 2, rxq[i]);
	endtask : t_rx

	// Two reply bits back to back, then host turns round
	task automatic t_reply();
		int n;
		hq.delete();
		rq.delete();
		chk("ready early", 0, tx_ready);
		@(posedge clk);
		tx_valid <= 1'b1;
		tx_bit <= 1'b1;
		for (n = 0; n < 9000 && tx_ready !== 1'b1; n++) @(negedge clk);
		@(posedge clk);
		tx_bit <= 1'b0;
		#1;
		rng("reply wait", 3800, 3900, quiet);
		chk("busy in slot", 1, tx_busy);
		for (n = 0; n < 6000 && tx_ready !== 1'b1; n++) @(negedge clk);
		@(posedge clk);
		tx_valid <= 1'b0;
		for (n = 0; n < 6000 && tx_busy !== 1'b0; n++) @(negedge clk);
		chk("busy after slot", 0, tx_busy);
		chk("reply count", 2, hq.size());
		rng("one low", 640, 1000, hq[0]);
		rng("zero low", 1600, 2900, hq[1]);
		rng("reply slot", 3800, 5000, rq[1] - rq[0]);
		@(posedge clk);
		rxq.delete();
		u_host.turn();
		u_host.send(10);
		chk("after reply", 1, rxq.size());
		chk("after reply bit", 1, rxq[0]);
	endtask : t_reply

	// Break, long hold reset, then a fresh bit
	task automatic t_break();
		int b = n_brk;
		int r = n_lrst;
		rxq.delete();
		u_host.brk();
		chk("break pulse", b + 1, n_brk);
		chk("no reset", r, n_lrst);
		u_host.pulse(RST_N + 10, 800);
		chk("hold break", b + 2, n_brk);
		chk("link reset", r + 1, n_lrst);
		u_host.send(1720);
		chk("rearm count", 1, rxq.size());
		chk("rearm bit", 0, rxq[0]);
	endtask : t_break

	// Enable low across a long low: nothing counts, then decode resumes
	task automatic t_freeze();
		int b = n_brk;
		rxq.delete();
		ce <= 1'b0;
		u_host.brk();
		ce <= 1'b1;
		chk("frozen break", b, n_brk);
		chk("frozen bits", 0, rxq.size());
		u_host.send(1000);
		chk("thawed count", 1, rxq.size());
		chk("thawed bit", 1, rxq[0]);
	endtask : t_freeze

	// Standard and fast clocking, then stuck-low lows
	task automatic t_scl();
		int s = n_scl;
		u_host.scl_run(20, 100, 100);
		u_host.scl_run(20, 26, 24);
		u_host.scl_hold(RST_N - 10);
		chk("short low", s, n_scl);
		u_host.scl_hold(RST_N + 10);
		chk("stuck low", s + 1, n_scl);
	endtask : t_scl

	// ****************************************************************
	// Main sequence, watchdog and verdict
	// ****************************************************************
	task automatic end_sim();
		$display("Checks made %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	initial
	begin
		sys_rst = 1'b1;
		ce = 1'b1;
		tx_valid = 1'b0;
		tx_bit = 1'b0;
		// Nine edges here plus the release edge give ten in reset
		repeat (9) @(posedge clk);
		#1;
		chk("oe in reset", 0, lw_oe);
		chk("ready in reset", 0, tx_ready);
		chk("out in reset", 0, lw_out);
		chk("busy in reset", 0, tx_busy);
		@(posedge clk);
		sys_rst <= 1'b0;
		t_rx();
		t_reply();
		t_break();
		t_freeze();
		t_scl();
		end_sim();
	end

	// Run needs about 75000 cycles; cut off at 100000
	initial
	begin
		#5000000;
		mismatches++;
		end_sim();
	end
endmodule : host_link_bit_timing_bench
